// ===== logic/dic_pkg.sv
// Purpose: constants and types for the drive input conditioning block
// Assumes: 12-bit unsigned analogue codes, full scale 10 V or 20 mA at 4096 codes
// Notes:   percentages are signed fixed point (speed 0.01 %, analogue 0.1 %)
//
// Notes on behaviour
// R01: the speed demand leaving the block never rises above the upper bound, default +110.00 %.
// R02: the speed demand leaving the block never falls below the lower bound, default -110.00 %, unless it is set above the upper bound, which then wins.
// R03: each digital input has an invert bit that flips its sense when 1 and passes it when 0.
// R04: each of the seven digital inputs shows a readable value after inversion, 1 true, 0 false.
// R05: each analogue input has a two-bit range code and is normalised to 0..100 % of that range.
// R06: each analogue result is normalised reading times gain plus bias, both within +/-300.0 %.
// R07: each analogue input shows a readable percentage after gain and bias.
// R08: reset loads every default and recomputes all derived values before any is presented; results_valid rises after 3 clocks, din_value settles after 5.
package dic_pkg;

    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [5:0] ADR_DIN_INVERT  = 6'h00;
    localparam logic [5:0] ADR_SPD_UPPER   = 6'h04;
    localparam logic [5:0] ADR_SPD_LOWER   = 6'h08;
    localparam logic [5:0] ADR_AIN_RANGE   = 6'h0c;
    localparam logic [5:0] ADR_AIN1_GAIN   = 6'h10;
    localparam logic [5:0] ADR_AIN1_BIAS   = 6'h14;
    localparam logic [5:0] ADR_AIN2_GAIN   = 6'h18;
    localparam logic [5:0] ADR_AIN2_BIAS   = 6'h1c;
    localparam logic [5:0] ADR_DIN_VALUE   = 6'h20;
    localparam logic [5:0] ADR_AIN1_RESULT = 6'h24;
    localparam logic [5:0] ADR_AIN2_RESULT = 6'h28;
    localparam logic [5:0] ADR_SPD_OUT     = 6'h2c;

    // ---------------------------------------------------------------
    // reset values and limits
    // ---------------------------------------------------------------
    localparam logic [6:0]  DIN_INVERT_DEF = 7'h10;   // input 5 inverted
    localparam logic [15:0] SPD_LIMIT      = 16'h2af8; // 110.00 %
    localparam logic [15:0] SPD_UPPER_DEF  = 16'h2af8; // +110.00 %
    localparam logic [15:0] SPD_LOWER_DEF  = 16'hd508; // -110.00 %
    localparam logic [15:0] AIN_LIMIT      = 16'h0bb8; // 300.0 %
    localparam logic [15:0] AIN_GAIN_DEF   = 16'h03e8; // 100.0 %
    localparam logic [15:0] AIN_BIAS_DEF   = 16'h0000; // 0.0 %
    localparam logic [1:0]  AIN1_RANGE_DEF = 2'h0;
    localparam logic [1:0]  AIN2_RANGE_DEF = 2'h3;
    localparam int          FRAC_POS       = 12;       // analogue code width
    localparam logic [31:0] GAIN_UNITY     = 32'h0000_03e8;

    // ---------------------------------------------------------------
    // normalisation constants, result in 0.1 % of range
    // ---------------------------------------------------------------
    localparam logic [10:0] NORM_FULL = 11'h3e8;  // 100.0 %
    localparam logic [11:0] MUL_FULL  = 12'h3e8;  // 0-10 V and 0-20 mA
    localparam logic [11:0] MUL_HALF  = 12'h7d0;  // 0-5 V
    localparam logic [11:0] MUL_LIVE  = 12'h4e2;  // 4-20 mA span
    localparam logic [11:0] LIVE_ZERO = 12'h333;  // code of 4 mA

    typedef enum logic [1:0] {
        RNG_10V   = 2'h0,
        RNG_5V    = 2'h1,
        RNG_20MA  = 2'h2,
        RNG_420MA = 2'h3
    } dic_range_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } dic_bus_st_t;

    typedef struct packed {
        logic [6:0]  din_invert;
        logic [15:0] spd_upper;
        logic [15:0] spd_lower;
        logic [1:0]  ain1_range;
        logic [1:0]  ain2_range;
        logic [15:0] ain1_gain;
        logic [15:0] ain1_bias;
        logic [15:0] ain2_gain;
        logic [15:0] ain2_bias;
    } dic_cfg_t;

endpackage

// ===== logic/dic_top.sv
// Purpose: input inversion, analogue scaling and speed demand clamping
// Assumes: analogue codes and speed demand come from logic on core_clk
// Notes:   register writes are held off (waitrequest) until defaults are settled
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module dic_top
    import dic_pkg::*;
(
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               arst_n,
    // avalon-mm slave
    input  wire logic [5:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    // terminal and converter inputs
    input  wire logic [6:0]         din_pin,
    input  wire logic [11:0]        ain1_code,
    input  wire logic [11:0]        ain2_code,
    input  wire logic signed [15:0] speed_demand_in,
    // conditioned outputs
    output logic [6:0]              din_value,
    output logic signed [15:0]      analog_in_result_1,
    output logic signed [15:0]      analog_in_result_2,
    output logic signed [15:0]      speed_demand_out,
    output logic                    results_valid
);

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    function automatic logic [10:0] normalise(input logic [11:0] code, input logic [1:0] rng);
        logic [31:0] t;
        t = 32'h0;
        case (rng)
            RNG_5V:    t = ({20'h0, code} * {20'h0, MUL_HALF}) >> FRAC_POS;
            RNG_420MA: t = (code < LIVE_ZERO) ? 32'h0 :
                           ({20'h0, code - LIVE_ZERO} * {20'h0, MUL_LIVE}) >> FRAC_POS;
            default:   t = ({20'h0, code} * {20'h0, MUL_FULL}) >> FRAC_POS;
        endcase
        return (t > {21'h0, NORM_FULL}) ? NORM_FULL : t[10:0];
    endfunction
    function automatic logic [15:0] scale(input logic [10:0] n, input logic [15:0] g,
                                          input logic [15:0] b);
        logic signed [31:0] p;
        p = $signed({21'h0, n}) * $signed({{16{g[15]}}, g});
        p = p / $signed(GAIN_UNITY);
        p = p + $signed({{16{b[15]}}, b});
        return p[15:0];
    endfunction
    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be, input logic [15:0] lim);
        logic [15:0] v;
        v = old;
        if (be[0])
            v[7:0] = wd[7:0];
        if (be[1])
            v[15:8] = wd[15:8];
        if ($signed(v) > $signed(lim))
            v = lim;
        else if ($signed(v) < -$signed(lim))
            v = -lim;
        return v;
    endfunction

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_q1_r;
    logic rst_n;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_q1_r <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_q1_r <= 1'b1;
            rst_n    <= rst_q1_r;
        end
    end

    // ---------------------------------------------------------------
    // digital inputs
    // ---------------------------------------------------------------
    dic_cfg_t   cfg_r, cfg_nxt;
    logic [6:0] s1_r, s2_r, s3_r, stable_r, stable_nxt, din_value_nxt;
    always_comb
    begin
        stable_nxt    = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & stable_r);
        din_value_nxt = stable_r ^ cfg_r.din_invert;              // see R03
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r      <= 7'h00;
            s2_r      <= 7'h00;
            s3_r      <= 7'h00;
            stable_r  <= 7'h00;
            din_value <= 7'h00;
        end
        else
        begin
            s1_r      <= din_pin;
            s2_r      <= s1_r;
            s3_r      <= s2_r;
            stable_r  <= stable_nxt;
            din_value <= din_value_nxt;                          // see R04
        end
    end

    // ---------------------------------------------------------------
    // analogue and speed path
    // ---------------------------------------------------------------
    logic [10:0]        norm1_r, norm2_r, norm1_nxt, norm2_nxt;
    logic signed [15:0] res1_nxt, res2_nxt, spd_nxt;
    logic [1:0]         warm_r, warm_nxt;
    logic               valid_nxt;
    always_comb
    begin
        norm1_nxt = normalise(ain1_code, cfg_r.ain1_range);      // see R05
        norm2_nxt = normalise(ain2_code, cfg_r.ain2_range);      // see R05
        res1_nxt  = $signed(scale(norm1_r, cfg_r.ain1_gain, cfg_r.ain1_bias)); // see R06
        res2_nxt  = $signed(scale(norm2_r, cfg_r.ain2_gain, cfg_r.ain2_bias)); // see R06
        spd_nxt   = speed_demand_in;
        if (spd_nxt < $signed(cfg_r.spd_lower))
            spd_nxt = $signed(cfg_r.spd_lower);                  // see R02
        if (spd_nxt > $signed(cfg_r.spd_upper))
            spd_nxt = $signed(cfg_r.spd_upper);                  // see R01
        warm_nxt  = (warm_r == 2'h2) ? warm_r : warm_r + 2'h1;
        valid_nxt = (warm_r == 2'h2);                            // see R08
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            norm1_r            <= 11'h000;
            norm2_r            <= 11'h000;
            analog_in_result_1 <= 16'sh0000;
            analog_in_result_2 <= 16'sh0000;
            speed_demand_out   <= 16'sh0000;
            warm_r             <= 2'h0;
            results_valid      <= 1'b0;
        end
        else
        begin
            norm1_r            <= norm1_nxt;
            norm2_r            <= norm2_nxt;
            analog_in_result_1 <= res1_nxt;                      // see R07
            analog_in_result_2 <= res2_nxt;                      // see R07
            speed_demand_out   <= spd_nxt;
            warm_r             <= warm_nxt;
            results_valid      <= valid_nxt;
        end
    end

    // ---------------------------------------------------------------
    // register bus
    // ---------------------------------------------------------------
    dic_bus_st_t st_r, st_nxt;
    logic [31:0] rdata_nxt;
    logic        wait_nxt;
    logic        take;
    always_comb
    begin
        cfg_nxt   = cfg_r;
        st_nxt    = st_r;
        rdata_nxt = avs_readdata;
        wait_nxt  = 1'b1;
        take      = 1'b0;
        case (st_r)
            BUS_IDLE:
            begin
                take = (avs_read ^ avs_write) && results_valid;  // see R08
                if (take)
                begin
                    st_nxt    = BUS_ACK;
                    wait_nxt  = 1'b0;
                    rdata_nxt = 32'h0;
                end
            end
            BUS_ACK: st_nxt = BUS_IDLE;
            default: st_nxt = BUS_IDLE;
        endcase
        if (take && avs_write)
        begin
            case (avs_address)
                ADR_DIN_INVERT:
                    if (avs_byteenable[0])
                        cfg_nxt.din_invert = avs_writedata[6:0];
                ADR_SPD_UPPER:
                    cfg_nxt.spd_upper = wmerge(cfg_r.spd_upper, avs_writedata,
                                               avs_byteenable, SPD_LIMIT);
                ADR_SPD_LOWER:
                    cfg_nxt.spd_lower = wmerge(cfg_r.spd_lower, avs_writedata,
                                               avs_byteenable, SPD_LIMIT);
                ADR_AIN_RANGE:
                    if (avs_byteenable[0])
                        {cfg_nxt.ain2_range, cfg_nxt.ain1_range} = avs_writedata[3:0];
                ADR_AIN1_GAIN:
                    cfg_nxt.ain1_gain = wmerge(cfg_r.ain1_gain, avs_writedata,
                                               avs_byteenable, AIN_LIMIT);
                ADR_AIN1_BIAS:
                    cfg_nxt.ain1_bias = wmerge(cfg_r.ain1_bias, avs_writedata,
                                               avs_byteenable, AIN_LIMIT);
                ADR_AIN2_GAIN:
                    cfg_nxt.ain2_gain = wmerge(cfg_r.ain2_gain, avs_writedata,
                                               avs_byteenable, AIN_LIMIT);
                ADR_AIN2_BIAS:
                    cfg_nxt.ain2_bias = wmerge(cfg_r.ain2_bias, avs_writedata,
                                               avs_byteenable, AIN_LIMIT);
                default:
                    cfg_nxt = cfg_r;
            endcase
        end
        if (take && avs_read)
        begin
            case (avs_address)
                ADR_DIN_INVERT:  rdata_nxt = {25'h0, cfg_r.din_invert};
                ADR_SPD_UPPER:   rdata_nxt = {{16{cfg_r.spd_upper[15]}}, cfg_r.spd_upper};
                ADR_SPD_LOWER:   rdata_nxt = {{16{cfg_r.spd_lower[15]}}, cfg_r.spd_lower};
                ADR_AIN_RANGE:   rdata_nxt = {28'h0, cfg_r.ain2_range, cfg_r.ain1_range};
                ADR_AIN1_GAIN:   rdata_nxt = {{16{cfg_r.ain1_gain[15]}}, cfg_r.ain1_gain};
                ADR_AIN1_BIAS:   rdata_nxt = {{16{cfg_r.ain1_bias[15]}}, cfg_r.ain1_bias};
                ADR_AIN2_GAIN:   rdata_nxt = {{16{cfg_r.ain2_gain[15]}}, cfg_r.ain2_gain};
                ADR_AIN2_BIAS:   rdata_nxt = {{16{cfg_r.ain2_bias[15]}}, cfg_r.ain2_bias};
                ADR_DIN_VALUE:   rdata_nxt = {25'h0, din_value};               // see R04
                ADR_AIN1_RESULT: rdata_nxt = 32'(analog_in_result_1);          // see R07
                ADR_AIN2_RESULT: rdata_nxt = 32'(analog_in_result_2);          // see R07
                ADR_SPD_OUT:     rdata_nxt = 32'(speed_demand_out);
                default:         rdata_nxt = 32'h0;
            endcase
        end
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_r           <= '{DIN_INVERT_DEF, SPD_UPPER_DEF, SPD_LOWER_DEF,
                                 AIN1_RANGE_DEF, AIN2_RANGE_DEF, AIN_GAIN_DEF,
                                 AIN_BIAS_DEF, AIN_GAIN_DEF, AIN_BIAS_DEF}; // see R08
            st_r            <= BUS_IDLE;
            avs_readdata    <= 32'h0;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            cfg_r           <= cfg_nxt;
            st_r            <= st_nxt;
            avs_readdata    <= rdata_nxt;
            avs_waitrequest <= wait_nxt;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    upper_clamp_a: assert property (speed_demand_out <=                     // see R01
        $signed($past(cfg_r.spd_upper))) else $error("speed demand above upper bound");
    lower_clamp_a: assert property ($past($signed(cfg_r.spd_lower) <=       // see R02
        $signed(cfg_r.spd_upper)) |-> speed_demand_out >= $signed($past(cfg_r.spd_lower)))
        else $error("speed demand below lower bound");
    pass_through_a: assert property (speed_demand_in <= $signed(cfg_r.spd_upper) && // see R01
        speed_demand_in >= $signed(cfg_r.spd_lower) |=>
        speed_demand_out == $past(speed_demand_in)) else $error("in-range speed demand altered");
    din_invert_a: assert property ($past(rst_n) |->                         // see R03
        din_value == ($past(stable_r) ^ $past(cfg_r.din_invert)))
        else $error("digital inversion wrong");
    din_settle_a: assert property (($stable(s3_r) && s2_r == s3_r) [*3] |=> // see R04
        din_value == (s3_r ^ $past(cfg_r.din_invert))) else $error("settled input not shown");
    norm_range_a: assert property (norm1_r <= NORM_FULL && norm2_r <= NORM_FULL)  // see R05
        else $error("normalised reading above full range");
    ain_scale_a: assert property (##1 analog_in_result_1 ==                 // see R06
        $signed(scale($past(norm1_r), $past(cfg_r.ain1_gain), $past(cfg_r.ain1_bias))))
        else $error("analogue result mismatch");
    ain_read_a: assert property (take && avs_read && avs_address == ADR_AIN2_RESULT // see R07
        |=> avs_readdata == 32'($past(analog_in_result_2)))
        else $error("analogue readback mismatch");
    reset_defaults_a: assert property (!results_valid |-> avs_waitrequest &&   // see R08
        cfg_r.spd_upper == SPD_UPPER_DEF && cfg_r.ain1_gain == AIN_GAIN_DEF &&
        cfg_r.din_invert == DIN_INVERT_DEF) else $error("defaults disturbed before valid");
    bus_ack_a: assert property (take |=> !avs_waitrequest ##1 avs_waitrequest) // see R07
        else $error("bus answer not one cycle");
    wr_seen_c:   cover property (take && avs_write ##1 !avs_waitrequest);
    rd_seen_c:   cover property (take && avs_read ##1 !avs_waitrequest);
    up_clamp_c:  cover property (speed_demand_in > $signed(cfg_r.spd_upper));
    low_clamp_c: cover property (speed_demand_in < $signed(cfg_r.spd_lower));
endmodule

// ===== test/dic_term_model.sv
// Purpose: model of the drive terminals, converters and speed loop feeding the block
// Assumes: commanded levels change just after a rising edge of core_clk
// Notes:   each level reaches the block one clock after the bench commands it
`timescale 1ns/10ps
module dic_term_model
(
    // clock
    input  wire logic               core_clk,
    // levels commanded by the bench
    input  wire logic [6:0]         cmd_pin,
    input  wire logic [11:0]        cmd_ain1,
    input  wire logic [11:0]        cmd_ain2,
    input  wire logic signed [15:0] cmd_speed,
    // levels presented to the block
    output logic [6:0]              din_pin = 7'h00,
    output logic [11:0]             ain1_code = 12'h000,
    output logic [11:0]             ain2_code = 12'h000,
    output logic signed [15:0]      speed_demand_in = 16'sh0000
);
    // converters and speed loop are sampled, so every level lags one clock
    always @(posedge core_clk)
    begin
        din_pin         <= cmd_pin;
        ain1_code       <= cmd_ain1;
        ain2_code       <= cmd_ain2;
        speed_demand_in <= cmd_speed;
    end
endmodule

// ===== test/tb.sv
// Purpose: self-checking bench for the input conditioning block
// Assumes: register access over avalon-mm, one clock of 25 MHz
// Notes:   expected values are worked out here from the fixed-point units
`timescale 1ns/10ps
module tb
    import dic_pkg::*;
;
    logic               core_clk = 1'b0;
    logic               arst_n = 1'b0;
    logic [5:0]         avs_address = 6'h00;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic [31:0]        avs_writedata = 32'h0000_0000;
    logic [3:0]         avs_byteenable = 4'h0;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic [6:0]         din_pin;
    logic [11:0]        ain1_code;
    logic [11:0]        ain2_code;
    logic signed [15:0] speed_demand_in;
    logic [6:0]         din_value;
    logic signed [15:0] analog_in_result_1;
    logic signed [15:0] analog_in_result_2;
    logic signed [15:0] speed_demand_out;
    logic               results_valid;
    logic [6:0]         cmd_pin = 7'h00;
    logic [11:0]        cmd_ain1 = 12'h800;
    logic [11:0]        cmd_ain2 = 12'h3e8;
    logic signed [15:0] cmd_speed = 16'sh2ee0;
    logic [31:0]        rd;
    int                 fail_count = 0;
    int                 checks = 0;

    dic_top dic_top_i (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .din_pin(din_pin), .ain1_code(ain1_code),
        .ain2_code(ain2_code), .speed_demand_in(speed_demand_in), .din_value(din_value),
        .analog_in_result_1(analog_in_result_1), .analog_in_result_2(analog_in_result_2),
        .speed_demand_out(speed_demand_out), .results_valid(results_valid));

    dic_term_model dic_term_model_i (.core_clk(core_clk), .cmd_pin(cmd_pin),
        .cmd_ain1(cmd_ain1), .cmd_ain2(cmd_ain2), .cmd_speed(cmd_speed), .din_pin(din_pin),
        .ain1_code(ain1_code), .ain2_code(ain2_code), .speed_demand_in(speed_demand_in));

    initial
    begin
        forever #20 core_clk = ~core_clk;
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= (a == ADR_DIN_INVERT || a == ADR_AIN_RANGE) ? 4'h1 : 4'h3;
        avs_write      <= wr;
        avs_read       <= !wr;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 500);
        chk("bus answer", {31'h0, avs_waitrequest}, 32'h0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rchk(input string what, input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // normalised reading in 0.1 % of the selected range
    function automatic int norm(input int rng, input int code);
        int v;
        case (rng)
            1:       v = code * 2000 / 4096;
            3:       v = (code < 819) ? 0 : (code - 819) * 1250 / 4096;
            default: v = code * 1000 / 4096;
        endcase
        return (v > 1000) ? 1000 : v;
    endfunction

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_defaults;
        rchk("invert", ADR_DIN_INVERT, 32'h0000_0010);
        rchk("upper", ADR_SPD_UPPER, 32'h0000_2af8);
        rchk("lower", ADR_SPD_LOWER, 32'hffff_d508);
        rchk("range", ADR_AIN_RANGE, 32'h0000_000c);
        rchk("gain1", ADR_AIN1_GAIN, 32'h0000_03e8);
        rchk("bias1", ADR_AIN1_BIAS, 32'h0000_0000);
        rchk("gain2", ADR_AIN2_GAIN, 32'h0000_03e8);
        rchk("bias2", ADR_AIN2_BIAS, 32'h0000_0000);
        rchk("unmapped", 6'h30, 32'h0000_0000);
        chk("din", 32'(din_value), 32'h0000_0010);
        chk("ain1", 32'(analog_in_result_1), 32'd500);
        rchk("ain2", ADR_AIN2_RESULT, 32'd55);
        chk("speed", 32'(speed_demand_out), 32'd11000);
        chk("valid", {31'h0, results_valid}, 32'h1);
    endtask

    task automatic t_digital;
        logic [6:0] inv [2] = '{7'h0f, 7'h00};
        cmd_pin <= 7'h55;
        for (int i = 0; i < 2; i++)
        begin
            wr(ADR_DIN_INVERT, {25'h0, inv[i]});
            tick(10);
            chk("din", 32'(din_value), 32'(7'h55 ^ inv[i]));
            rchk("din reg", ADR_DIN_VALUE, 32'(7'h55 ^ inv[i]));
        end
        wr(6'h30, 32'h0000_ffff);
        rchk("invert kept", ADR_DIN_INVERT, 32'h0000_0000);
    endtask

    task automatic t_analog;
        int c1 [4] = '{2048, 1024, 4095, 500};
        int c2 [4] = '{2047, 100, 3000, 500};
        int e1;
        int e2;
        wr(ADR_AIN1_GAIN, 32'h0000_0fa0);
        rchk("gain sat", ADR_AIN1_GAIN, 32'h0000_0bb8);
        wr(ADR_AIN1_GAIN, 32'd2000);
        wr(ADR_AIN1_BIAS, 32'hffff_ffce);
        wr(ADR_AIN2_GAIN, 32'hffff_fa24);
        wr(ADR_AIN2_BIAS, 32'd300);
        for (int r = 0; r < 4; r++)
        begin
            wr(ADR_AIN_RANGE, 32'((3 - r) * 4 + r));
            cmd_ain1 <= 12'(c1[r]);
            cmd_ain2 <= 12'(c2[r]);
            tick(6);
            e1 = norm(r, c1[r]) * 2000 / 1000 - 50;
            e2 = norm(3 - r, c2[r]) * (-1500) / 1000 + 300;
            chk("ain1", 32'(analog_in_result_1), 32'(e1));
            rchk("ain2", ADR_AIN2_RESULT, 32'(e2));
            chk("ain2 port", 32'(analog_in_result_2), 32'(e2));
            rchk("ain1 reg", ADR_AIN1_RESULT, 32'(e1));
        end
    endtask

    task automatic t_speed;
        int sp [3] = '{7000, -8000, 1234};
        int ex [3] = '{5000, -3000, 1234};
        cmd_speed <= -16'sd12000;
        tick(4);
        chk("speed", 32'(speed_demand_out), 32'hffff_d508);
        wr(ADR_SPD_UPPER, 32'd20000);
        rchk("upper sat", ADR_SPD_UPPER, 32'h0000_2af8);
        wr(ADR_SPD_LOWER, 32'hffff_b1e0);
        rchk("lower sat", ADR_SPD_LOWER, 32'hffff_d508);
        wr(ADR_SPD_UPPER, 32'd5000);
        wr(ADR_SPD_LOWER, 32'hffff_f448);
        for (int i = 0; i < 3; i++)
        begin
            cmd_speed <= 16'(sp[i]);
            tick(4);
            chk("speed", 32'(speed_demand_out), 32'(ex[i]));
        end
        rchk("speed reg", ADR_SPD_OUT, 32'd1234);
    endtask

    // ---------------------------------------------------------------
    // run control
    // ---------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge core_clk);
        chk("valid in reset", {31'h0, results_valid}, 32'h0);
        chk("held off", {31'h0, avs_waitrequest}, 32'h1);
        arst_n <= 1'b1;
        t_defaults;
        t_digital;
        t_analog;
        t_speed;
        wrap_up;
    end

    initial
    begin
        #(40 * 20000);
        fail_count++;
        wrap_up;
    end
endmodule
